/* bench/pio_pin_model.sv */
// pin-side model: general port wires with pull-ups, and the two comparators
`timescale 1ns/10ps
module pio_pin_model (
  // block pin side
  input  logic [7:0] gen_port_out,
  input  logic [7:0] gen_port_oe,
  input  logic       cmp_power_en,
  output logic [7:0] gen_port_in,
  output logic       cmp1_result,
  output logic       cmp2_result,
  // outside world
  input  logic [7:0] ext_drv,
  input  logic [7:0] ext_oe,
  input  logic [7:0] ana1,
  input  logic [7:0] ana2,
  input  logic [7:0] ref_lvl,
  input  logic [7:0] l3_lvl
);
  // a released line floats up to the pull-up, never holds its last value
  always_comb
    for (int i = 0; i < 8; i++)
      gen_port_in[i] = gen_port_oe[i] ? gen_port_out[i] : ext_oe[i] ? ext_drv[i] : 1'b1;
  // line 1 against the reference pin, line 2 against line 3; dead when unpowered
  assign cmp1_result = cmp_power_en && (ana1 > ref_lvl);
  assign cmp2_result = cmp_power_en && (ana2 > l3_lvl);
endmodule // pio_pin_model

/* bench/pio_top_monitor.sv */
// checker for the port block: bus handshakes, reset state and pin outputs
`timescale 1ns/10ps
module pio_top_monitor (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // register bus
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // pins and core side
  input logic [7:0]  gen_port_oe,
  input logic        stop_mode,
  input logic        cmp_power_en,
  input logic        aux_port_line4,
  input logic        aux_port_line7,
  input logic        aux_port_line4_route,
  input logic        aux_port_line7_route,
  input logic        line3_interrupt,
  input logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_all_in_a: assert property ($rose(aresetn) |-> gen_port_oe == 8'h00)
    else $error("general port not all inputs after reset");
  stop_pwr_off_a: assert property (stop_mode |=> !cmp_power_en)
    else $error("comparators powered in stop mode");
  route_gate_a: assert property ((aux_port_line4_route || !aux_port_line4) && (aux_port_line7_route || !aux_port_line7))
    else $error("comparator result on unrouted pin");
  l3_pulse_a: assert property (line3_interrupt |=> !line3_interrupt)
    else $error("line 3 interrupt longer than one cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  wr_answer_a: assert property (s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid && !s_axi_awready)
    else $error("write not answered one cycle after taking");
  rd_answer_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after taking");

  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (line3_interrupt);
  cover property ($rose(irq));
  cover property (aux_port_line4 && aux_port_line7);
endmodule // pio_top_monitor

bind pio_top pio_top_monitor u_mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gen_port_oe, .stop_mode,
  .cmp_power_en, .aux_port_line4, .aux_port_line7, .aux_port_line4_route, .aux_port_line7_route,
  .line3_interrupt, .irq);

/* bench/pio_top_tb.sv */
// self-checking bench for the port block
`timescale 1ns/10ps
module pio_top_tb;
  logic aclk = 0, aresetn = 0, clk_en = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] gen_port_in, gen_port_out, gen_port_oe, ext_drv = 0, ext_oe = 0;
  logic [7:0] ana1 = 0, ana2 = 0, ref_lvl = 0, l3_lvl = 0;
  logic aux_port_line1 = 0, aux_port_line2 = 0, aux_port_line3 = 0, stop_mode = 0, v;
  logic cmp1_result, cmp2_result, cmp_power_en, aux_port_line4, aux_port_line7, aux_port_line4_route;
  logic aux_port_line7_route, timer_edge_in, stop_recovery_source, line3_interrupt, irq;
  int err_total = 0, total_checks = 0, cyc = 0, slow = 0;
  // rows: offset, write value, read value, write resp, read resp
  logic [31:0] tab [8] = '{32'h00a5a500, 32'h040f0f00, 32'h08030300, 32'h0cc0c000,
                           32'h10030300, 32'h14070700, 32'h3055000a, 32'h24000002};

  pio_top uut (.*);
  pio_pin_model u_pins (.gen_port_out, .gen_port_oe, .cmp_power_en, .gen_port_in, .cmp1_result,
    .cmp2_result, .ext_drv, .ext_oe, .ana1, .ana2, .ref_lvl, .l3_lvl);

  always #50 aclk = ~aclk;

  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] got, e);
    total_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task wr(input logic [7:0] a, dat);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    repeat (slow) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task rd(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    repeat (slow) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task w(input logic [7:0] a, dat);
    wr(a, dat);
    chk(r, 0);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, 0);
  endtask

  // pins need two sync edges and one detect edge before they show
  task wt;
    repeat (4) @(posedge aclk);
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    foreach (tab[i])
    begin
      slow = i % 2;
      wr(tab[i][31:24], tab[i][23:16]);
      chk(r, tab[i][3:2]);
      rd(tab[i][31:24]);
      chk(d, tab[i][15:8]);
      chk(r, tab[i][1:0]);
    end
    slow = 0;
    // second reset in mid-run brings back the defaults
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(gen_port_oe, 0);
    rc(8'h04, 8'hff);
    rc(8'h08, 8'h00);
    // push-pull, then open-drain on the upper nibble
    w(8'h00, 8'ha5);
    w(8'h04, 8'h0f);
    ext_drv <= 8'h03;
    ext_oe <= 8'h0f;
    wt;
    chk(gen_port_oe, 8'hf0);
    chk(gen_port_out[7:4], 4'ha);
    rc(8'h1c, 8'ha3);
    w(8'h08, 8'h01);
    wt;
    chk(gen_port_oe, 8'h50);
    chk(gen_port_out, 8'h00);
    rc(8'h1c, 8'ha3);
    wr(8'h1c, 8'h00);
    chk(r, 2);
    // wake terms from the whole general port
    w(8'h08, 8'h00);
    w(8'h04, 8'hff);
    w(8'h14, 8'h00);
    ext_oe <= 8'hff;
    for (int k = 0; k < 3; k++)
    begin
      ext_drv <= (k == 0) ? 8'hff : k;
      wt;
      rc(8'h18, (k == 0) ? 8'h30 : 8'h10);
    end
    chk(stop_recovery_source, 1);
    w(8'h24, 8'h0f);
    w(8'h28, 8'h08);
    ext_drv <= 8'h00;
    wt;
    chk(irq, 0);
    ext_drv <= 8'h01;
    wt;
    chk(irq, 1);
    rc(8'h20, 8'h08);
    w(8'h28, 8'h00);
    wt;
    chk(irq, 0);
    w(8'h24, 8'h08);
    rc(8'h20, 8'h00);
    w(8'h14, 8'h04);
    wt;
    chk(stop_recovery_source, 0);
    // line 3 in digital mode
    w(8'h28, 8'h01);
    aux_port_line3 <= 1;
    wt;
    rc(8'h18, 8'h18);
    aux_port_line3 <= 0;
    v = 0;
    repeat (8)
    begin
      @(posedge aclk);
      v |= line3_interrupt;
    end
    chk(v, 1);
    chk(irq, 1);
    w(8'h24, 8'h0f);
    // comparators routed, stopped, then back to digital
    ana1 <= 8'h80;
    ref_lvl <= 8'h40;
    ana2 <= 8'h10;
    l3_lvl <= 8'h40;
    w(8'h10, 8'h03);
    w(8'h08, 8'h02);
    wt;
    chk(cmp_power_en, 1);
    chk({aux_port_line4, aux_port_line7, aux_port_line4_route, aux_port_line7_route}, 4'hb);
    ana2 <= 8'h50;
    aux_port_line3 <= 1;
    wt;
    chk(aux_port_line7, 1);
    chk(stop_recovery_source, 0);
    stop_mode <= 1;
    wt;
    chk({cmp_power_en, aux_port_line4}, 0);
    stop_mode <= 0;
    w(8'h08, 8'h00);
    wt;
    chk({aux_port_line4_route, aux_port_line7_route}, 0);
    chk(stop_recovery_source, 1);
    aux_port_line3 <= 0;
    // edge select codes on line 1
    for (int k = 0; k < 3; k++)
    begin
      w(8'h0c, k << 6);
      w(8'h24, 8'h0f);
      aux_port_line1 <= 1;
      wt;
      rd(8'h20);
      chk(d[1], k != 0);
      w(8'h24, 8'h0f);
      aux_port_line1 <= 0;
      wt;
      rd(8'h20);
      chk(d[1], k != 1);
    end
    // timer edge input selection
    w(8'h14, 8'h01);
    wt;
    chk(timer_edge_in, 1);
    w(8'h14, 8'h03);
    wt;
    chk(timer_edge_in, 0);
    aux_port_line1 <= 1;
    wt;
    chk(timer_edge_in, 1);
    // clock enable low freezes the pipeline and the output
    clk_en <= 0;
    aux_port_line1 <= 0;
    wt;
    chk(timer_edge_in, 1);
    clk_en <= 1;
    wt;
    chk(timer_edge_in, 0);
    w(8'h14, 8'h02);
    wt;
    chk(timer_edge_in, 0);
    print_verdict;
  end
endmodule // pio_top_tb

/* logic/pio_edge.v */
// edge detector with rising, falling or both-edge selection
`include "pio_regs.vh"
`timescale 1ns/10ps
module pio_edge (
  // clock, reset, enable
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clk_en,
  // level and mode
  input  wire       level,
  input  wire [1:0] sel,
  output wire       pulse
);

  reg  prev_ff;
  wire rise;
  wire fall;

  always @(posedge aclk)
  begin
    if (!aresetn)
      prev_ff <= 1'b0;
    else if (clk_en)
      prev_ff <= level;
  end

  assign rise  = level & ~prev_ff;
  assign fall  = ~level & prev_ff;
  // codes above rising mean both edges
  assign pulse = clk_en & ((sel == `PIO_EDGE_FALL) ? fall :
                           (sel == `PIO_EDGE_RISE) ? rise : (rise | fall));

endmodule // pio_edge

/* logic/pio_regs.vh */
// register offsets, field positions and reset values of the port block
// Contract
// - general port has eight lines, each set as input or output by software.
// - all general-port output lines share one drive: push-pull or open-drain.
// - after reset all eight general-port lines are inputs.
// - the eight general-port inputs feed an OR and an AND wake-up term.
// - in demodulation mode general line 0 can feed the timer edge detector.
// - comparators on the aux port work only while mode register bit 1 is set.
// - aux lines 1 and 2 interrupt on rising, falling or both edges, bits 7:6.
// - in analog mode lines 1 and 2 are compared against reference and line 3.
// - in analog mode line 3 interrupt comes from stop-recovery logic, lines 1-3 excluded.
// - in digital mode line 3 shows as bit 3 and its edges raise its interrupt; the code raises it on falling edges only.
// - both comparators are powered down while in stop mode.
// - the configuration register routes comparator results to aux lines 4 and 7.
// - timer edge input selects aux line 1 or general line 0.
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

`define PIO_ADDR_W        8
`define PIO_GP_OUT_OFS    8'h00
`define PIO_GP_DIR_OFS    8'h04
`define PIO_AUX_MODE_OFS  8'h08
`define PIO_IRQ_EDGE_OFS  8'h0c
`define PIO_PORT_CFG_OFS  8'h10
`define PIO_TMR_CFG_OFS   8'h14
`define PIO_AUX_IN_OFS    8'h18
`define PIO_GP_IN_OFS     8'h1c
`define PIO_IRQ_STAT_OFS  8'h20
`define PIO_IRQ_CLR_OFS   8'h24
`define PIO_IRQ_EN_OFS    8'h28

`define PIO_GP_OUT_RST    8'h00
`define PIO_GP_DIR_RST    8'hff
`define PIO_AUX_MODE_RST  8'h00
`define PIO_IRQ_EDGE_RST  8'h00
`define PIO_PORT_CFG_RST  8'h00
`define PIO_TMR_CFG_RST   8'h00
`define PIO_IRQ_EN_RST    4'h0

`define PIO_MODE_OD_BIT   0
`define PIO_MODE_ANA_BIT  1
`define PIO_EDGE_LO_BIT   6
`define PIO_EDGE_HI_BIT   7
`define PIO_CFG_CMP1_BIT  0
`define PIO_CFG_CMP2_BIT  1
`define PIO_TMR_DEMOD_BIT 0
`define PIO_TMR_SEL_BIT   1
`define PIO_TMR_AND_BIT   2

`define PIO_IRQ_L3_BIT    0
`define PIO_IRQ_L1_BIT    1
`define PIO_IRQ_L2_BIT    2
`define PIO_IRQ_WAKE_BIT  3
`define PIO_IRQ_W         4

`define PIO_EDGE_FALL     2'h0
`define PIO_EDGE_RISE     2'h1
`define PIO_RESP_OKAY     2'h0
`define PIO_RESP_SLVERR   2'h2

`endif

/* logic/pio_sync.v */
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/10ps
module pio_sync #(
  parameter W = 13
) (
  // clock, reset, enable
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         clk_en,
  // data
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pio_sync

/* logic/pio_top.v */
// general port, aux input port with comparators, and their register slave
`include "pio_regs.vh"
`timescale 1ns/10ps
module pio_top (
  // clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // general port pins
  input  wire [7:0]  gen_port_in,
  output wire [7:0]  gen_port_out,
  output wire [7:0]  gen_port_oe,
  // aux port digital input pins
  input  wire        aux_port_line1,
  input  wire        aux_port_line2,
  input  wire        aux_port_line3,
  // analog comparator front end
  input  wire        cmp1_result,
  input  wire        cmp2_result,
  output wire        cmp_power_en,
  // aux port comparator-routed outputs
  output wire        aux_port_line4,
  output wire        aux_port_line7,
  output wire        aux_port_line4_route,
  output wire        aux_port_line7_route,
  // core and timer side
  input  wire        stop_mode,
  output wire        timer_edge_in,
  output wire        stop_recovery_source,
  output wire        line3_interrupt,
  output wire        irq
);

  localparam AW = `PIO_ADDR_W;

  // registers
  reg [7:0]  gp_out_ff;
  reg [7:0]  gp_dir_ff;
  reg [7:0]  aux_mode_reg_ff;
  reg [7:0]  irq_edge_ff;
  reg [7:0]  port_configuration_reg_ff;
  reg [7:0]  tmr_cfg_ff;
  reg [`PIO_IRQ_W-1:0] irq_stat_ff;
  reg [`PIO_IRQ_W-1:0] irq_en_ff;

  // bus state
  reg        awready_ff;
  reg        wready_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;
  reg        arready_ff;
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0]  rresp_ff;

  // pin and output flops
  reg [7:0]  gp_pin_out_ff;
  reg [7:0]  gp_pin_oe_ff;
  reg        cmp_pwr_ff;
  reg        line4_ff;
  reg        line7_ff;
  reg        line4_route_ff;
  reg        line7_route_ff;
  reg        timer_edge_ff;
  reg        smr_src_ff;
  reg        line3_irq_ff;
  reg        irq_ff;

  // synchronised inputs
  wire [12:0] sync_in;
  wire [7:0]  gp_s;
  wire        aux1_s;
  wire        aux2_s;
  wire        aux3_s;
  wire        cmp1_s;
  wire        cmp2_s;

  pio_sync #(
    .W (13)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_en   (clk_en),
    .async_in ({cmp2_result, cmp1_result, aux_port_line3, aux_port_line2, aux_port_line1, gen_port_in}),
    .sync_out (sync_in)
  );

  assign gp_s   = sync_in[7:0];
  assign aux1_s = sync_in[8];
  assign aux2_s = sync_in[9];
  assign aux3_s = sync_in[10];
  assign cmp1_s = sync_in[11];
  assign cmp2_s = sync_in[12];

  // mode decode
  wire analog_mode = aux_mode_reg_ff[`PIO_MODE_ANA_BIT];
  wire open_drain  = aux_mode_reg_ff[`PIO_MODE_OD_BIT];
  wire demod_mode  = tmr_cfg_ff[`PIO_TMR_DEMOD_BIT];
  wire demod_aux   = tmr_cfg_ff[`PIO_TMR_SEL_BIT];
  wire wake_and_en = tmr_cfg_ff[`PIO_TMR_AND_BIT];
  wire cmp_on      = analog_mode & ~stop_mode;

  // comparator results are meaningless while powered down, so they read low
  wire cmp1_v = cmp_on & cmp1_s;
  wire cmp2_v = cmp_on & cmp2_s;
  wire line1_v = analog_mode ? cmp1_v : aux1_s;
  wire line2_v = analog_mode ? cmp2_v : aux2_s;
  // line 3 is a reference in analog mode, so its digital bit reads low
  wire line3_v = ~analog_mode & aux3_s;

  // wake-up gates over the eight general-port inputs
  wire wake_or   = |gp_s;
  wire wake_and  = &gp_s;
  wire wake_term = wake_and_en ? wake_and : wake_or;

  // in analog mode lines 1-3 drop out of stop recovery
  wire nxt_smr_src = wake_term |
                     (~analog_mode & (aux1_s | aux2_s | aux3_s));

  // line 3 interrupt level: pin in digital mode, recovery logic in analog
  wire l3_level = analog_mode ? nxt_smr_src : aux3_s;

  wire ev_l1;
  wire ev_l2;
  wire ev_l3;
  wire ev_wake;

  pio_edge u_edge_l1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .level   (line1_v),
    .sel     (irq_edge_ff[`PIO_EDGE_HI_BIT:`PIO_EDGE_LO_BIT]),
    .pulse   (ev_l1)
  );

  pio_edge u_edge_l2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .level   (line2_v),
    .sel     (irq_edge_ff[`PIO_EDGE_HI_BIT:`PIO_EDGE_LO_BIT]),
    .pulse   (ev_l2)
  );

  pio_edge u_edge_l3 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .level   (l3_level),
    .sel     (`PIO_EDGE_FALL),
    .pulse   (ev_l3)
  );

  pio_edge u_edge_wake (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .level   (wake_term),
    .sel     (`PIO_EDGE_RISE),
    .pulse   (ev_wake)
  );

  wire [`PIO_IRQ_W-1:0] events = {ev_wake, ev_l2, ev_l1, ev_l3};

  // axi4-lite decode
  wire [AW-1:0] wa = s_axi_awaddr[AW-1:0];
  wire [AW-1:0] ra = s_axi_araddr[AW-1:0];
  wire wr_hit = s_axi_awvalid & s_axi_wvalid & awready_ff & wready_ff;
  wire rd_hit = s_axi_arvalid & arready_ff;
  wire wr_lo  = wr_hit & s_axi_wstrb[0];
  wire wa_hi  = |s_axi_awaddr[31:AW];
  wire ra_hi  = |s_axi_araddr[31:AW];

  reg        wr_ok;
  reg        rd_ok;
  reg [31:0] rd_val;

  always @*
  begin
    wr_ok = ~wa_hi;
    case (wa)
      `PIO_GP_OUT_OFS,
      `PIO_GP_DIR_OFS,
      `PIO_AUX_MODE_OFS,
      `PIO_IRQ_EDGE_OFS,
      `PIO_PORT_CFG_OFS,
      `PIO_TMR_CFG_OFS,
      `PIO_IRQ_CLR_OFS,
      `PIO_IRQ_EN_OFS: wr_ok = ~wa_hi;
      default:         wr_ok = 1'b0;
    endcase
  end

  always @*
  begin
    rd_ok  = ~ra_hi;
    rd_val = 32'h0000_0000;
    case (ra)
      `PIO_GP_OUT_OFS:   rd_val = {24'h00_0000, gp_out_ff};
      `PIO_GP_DIR_OFS:   rd_val = {24'h00_0000, gp_dir_ff};
      `PIO_AUX_MODE_OFS: rd_val = {24'h00_0000, aux_mode_reg_ff};
      `PIO_IRQ_EDGE_OFS: rd_val = {24'h00_0000, irq_edge_ff};
      `PIO_PORT_CFG_OFS: rd_val = {24'h00_0000, port_configuration_reg_ff};
      `PIO_TMR_CFG_OFS:  rd_val = {24'h00_0000, tmr_cfg_ff};
      `PIO_AUX_IN_OFS:   rd_val = {26'h0, wake_and, wake_or, line3_v, line2_v, line1_v, 1'b0};
      `PIO_GP_IN_OFS:    rd_val = {24'h00_0000, gp_s};
      `PIO_IRQ_STAT_OFS: rd_val = {28'h000_0000, irq_stat_ff};
      `PIO_IRQ_EN_OFS:   rd_val = {28'h000_0000, irq_en_ff};
      default:           rd_ok  = 1'b0;
    endcase
    if (!rd_ok)
      rd_val = 32'h0000_0000;
  end

  // bus handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `PIO_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `PIO_RESP_OKAY;
    end
    else if (clk_en)
    begin
      // both channels are taken at the same edge, only once both are offered
      awready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      wready_ff  <= s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
      if (wr_hit)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
      arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
      if (rd_hit)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_val;
        rresp_ff  <= rd_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // control registers
  wire clr_hit = wr_lo & ~wa_hi & (wa == `PIO_IRQ_CLR_OFS);
  // a new event wins over a clear in the same cycle; irq follows this value so it drops with the clear
  wire [`PIO_IRQ_W-1:0] nxt_stat = (irq_stat_ff & ~(clr_hit ? s_axi_wdata[`PIO_IRQ_W-1:0] : {`PIO_IRQ_W{1'b0}})) |
                                   events;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gp_out_ff                 <= `PIO_GP_OUT_RST;
      gp_dir_ff                 <= `PIO_GP_DIR_RST;
      aux_mode_reg_ff           <= `PIO_AUX_MODE_RST;
      irq_edge_ff               <= `PIO_IRQ_EDGE_RST;
      port_configuration_reg_ff <= `PIO_PORT_CFG_RST;
      tmr_cfg_ff                <= `PIO_TMR_CFG_RST;
      irq_en_ff                 <= `PIO_IRQ_EN_RST;
      irq_stat_ff               <= {`PIO_IRQ_W{1'b0}};
    end
    else if (clk_en)
    begin
      if (wr_lo && !wa_hi)
      begin
        case (wa)
          `PIO_GP_OUT_OFS:   gp_out_ff                 <= s_axi_wdata[7:0];
          `PIO_GP_DIR_OFS:   gp_dir_ff                 <= s_axi_wdata[7:0];
          `PIO_AUX_MODE_OFS: aux_mode_reg_ff           <= s_axi_wdata[7:0];
          `PIO_IRQ_EDGE_OFS: irq_edge_ff               <= s_axi_wdata[7:0];
          `PIO_PORT_CFG_OFS: port_configuration_reg_ff <= s_axi_wdata[7:0];
          `PIO_TMR_CFG_OFS:  tmr_cfg_ff                <= s_axi_wdata[7:0];
          `PIO_IRQ_EN_OFS:   irq_en_ff                 <= s_axi_wdata[`PIO_IRQ_W-1:0];
          default:           gp_out_ff                 <= gp_out_ff;
        endcase
      end
      irq_stat_ff <= nxt_stat;
    end
  end

  // general port drive: one drive type for every output line
  wire [7:0] nxt_gp_pin_out = open_drain ? 8'h00 : gp_out_ff;
  wire [7:0] nxt_gp_pin_oe  = open_drain ? (~gp_dir_ff & ~gp_out_ff) : ~gp_dir_ff;

  // timer edge input, only live in demodulation mode
  wire nxt_timer_edge = demod_mode & (demod_aux ? line1_v : gp_s[0]);

  // comparator results onto aux lines 4 and 7
  wire route4 = port_configuration_reg_ff[`PIO_CFG_CMP1_BIT] & analog_mode;
  wire route7 = port_configuration_reg_ff[`PIO_CFG_CMP2_BIT] & analog_mode;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gp_pin_out_ff  <= 8'h00;
      gp_pin_oe_ff   <= 8'h00;
      cmp_pwr_ff     <= 1'b0;
      line4_ff       <= 1'b0;
      line7_ff       <= 1'b0;
      line4_route_ff <= 1'b0;
      line7_route_ff <= 1'b0;
      timer_edge_ff  <= 1'b0;
      smr_src_ff     <= 1'b0;
      line3_irq_ff   <= 1'b0;
      irq_ff         <= 1'b0;
    end
    else if (clk_en)
    begin
      gp_pin_out_ff  <= nxt_gp_pin_out;
      gp_pin_oe_ff   <= nxt_gp_pin_oe;
      cmp_pwr_ff     <= cmp_on;
      line4_ff       <= route4 & cmp1_v;
      line7_ff       <= route7 & cmp2_v;
      line4_route_ff <= route4;
      line7_route_ff <= route7;
      timer_edge_ff  <= nxt_timer_edge;
      smr_src_ff     <= nxt_smr_src;
      line3_irq_ff   <= ev_l3;
      irq_ff         <= |(nxt_stat & irq_en_ff);
    end
  end

  // outputs
  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign gen_port_out         = gp_pin_out_ff;
  assign gen_port_oe          = gp_pin_oe_ff;
  assign cmp_power_en         = cmp_pwr_ff;
  assign aux_port_line4       = line4_ff;
  assign aux_port_line7       = line7_ff;
  assign aux_port_line4_route = line4_route_ff;
  assign aux_port_line7_route = line7_route_ff;
  assign timer_edge_in        = timer_edge_ff;
  assign stop_recovery_source = smr_src_ff;
  assign line3_interrupt      = line3_irq_ff;
  assign irq                  = irq_ff;

endmodule // pio_top
